// *** rtl/lcnir_defs.svh ***
// lcnir_defs.svh: offsets, bit positions, reset values and timing counts
// assumes inclusion by bare name from the link control / node_identity_status files
`ifndef LCNIR_DEFS_SVH
`define LCNIR_DEFS_SVH

// register byte offsets on the apb window
`define LCNIR_OFS_LCTRL_SET   12'h000
`define LCNIR_OFS_LCTRL_CLR   12'h004
`define LCNIR_OFS_NODE_IDENTITY_STATUS     12'h008
`define LCNIR_OFS_EVENT       12'h00C
`define LCNIR_OFS_CYC_OFFSET  12'h010

// link control bit positions
`define LCNIR_LC_EXT_ROLL     0
`define LCNIR_LC_LEADER       1
`define LCNIR_LC_TIMER_EN     2
`define LCNIR_LC_PHY_PKT      3
`define LCNIR_LC_SELF_ID      4
`define LCNIR_LC_WIDTH        5
`define LCNIR_LC_RESET        5'h00

// event register bit positions
`define LCNIR_EV_OVERLONG     0

// node identity and status field positions
`define LCNIR_NI_VALID        31
`define LCNIR_NI_ROOT         30
`define LCNIR_NI_CABLE_PWR    27
`define LCNIR_NI_BUS_LSB      6
`define LCNIR_NI_BUS_MSB      15
`define LCNIR_NI_NODE_MSB     5
`define LCNIR_BUS_RESET       10'h3FF
`define LCNIR_NODE_RESET      6'h00

// cycle timer: 3072 periods of 24.576 MHz make one 125 us cycle
`define LCNIR_CYC_PERIOD_US   125
`define LCNIR_CYC_TICK_KHZ    24576
`define LCNIR_CYC_LAST        12'((`LCNIR_CYC_PERIOD_US * `LCNIR_CYC_TICK_KHZ) / 1000 - 1)

`endif

// *** rtl/lcnir_pkg.sv ***
// lcnir_pkg: types shared by the link control / node_identity_status register bank
// assumes lcnir_defs.svh for all numeric constants
package lcnir_pkg;

  typedef logic [4:0]  lcnir_lctrl_t;
  typedef logic [11:0] lcnir_offset_t;

  // which register an apb address selects
  typedef enum logic [2:0] {
    LCNIR_SEL_SET  = 3'b000,
    LCNIR_SEL_CLR  = 3'b001,
    LCNIR_SEL_NODE = 3'b010,
    LCNIR_SEL_EVT  = 3'b011,
    LCNIR_SEL_CYC  = 3'b100,
    LCNIR_SEL_NONE = 3'b111
  } lcnir_sel_t;

endpackage

// *** rtl/lcnir_cycle_offset.sv ***
// lcnir_cycle_offset: intra-period counter of the isochronous cycle timer
// assumes i_tick_24m is a one-cycle pulse per 24.576 MHz period, synchronous
`timescale 1ns/10ps
`include "lcnir_defs.svh"

module lcnir_cycle_offset
  import lcnir_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // control
  input  wire logic          i_count_en,
  input  wire logic          i_ext_sel,
  input  wire logic          i_ext_tick,
  input  wire logic          i_tick_24m,
  input  wire logic          i_load,
  input  wire lcnir_offset_t i_load_value,
  // state
  output lcnir_offset_t      o_offset,
  output logic               o_rollover
);

  lcnir_offset_t offset_r;
  logic          rollover_r;

  // a received cycle start outranks local counting so the follower re-aligns
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      offset_r   <= 12'h000;
      rollover_r <= 1'b0;
    end else begin
      rollover_r <= 1'b0;
      if (i_load) begin
        offset_r <= i_load_value;
      end else if (i_count_en) begin
        if (i_ext_sel && i_ext_tick) begin
          offset_r   <= 12'h000;
          rollover_r <= 1'b1;
        end else if (i_tick_24m) begin
          // >= also recovers a count left above 3071 by external mode
          if (!i_ext_sel && offset_r >= `LCNIR_CYC_LAST) begin
            offset_r   <= 12'h000;
            rollover_r <= 1'b1;
          end else begin
            offset_r <= offset_r + 12'h001;
          end
        end
      end
    end
  end

  assign o_offset   = offset_r;
  assign o_rollover = rollover_r;

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_count_en && i_tick_24m && !i_ext_sel && !i_load && offset_r == 12'hBFF)
      |=> (offset_r == 12'h000 && rollover_r);
  endproperty
  a_wrap: assert property (p_wrap) else $error("offset did not wrap at 3071");

  property p_modulo;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_ext_sel |-> offset_r <= 12'hBFF;
  endproperty
  a_modulo: assert property (p_modulo) else $error("offset above 3071");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!i_count_en && !i_load) |=> ($stable(offset_r) && !rollover_r);
  endproperty
  a_hold: assert property (p_hold) else $error("offset moved while disabled");

  property p_ext;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ext_sel && i_count_en && i_tick_24m && !i_ext_tick && !i_load
      && offset_r == 12'hBFF) |=> (offset_r == 12'hC00 && !rollover_r);
  endproperty
  a_ext: assert property (p_ext) else $error("internal wrap in external mode");

endmodule

// *** rtl/lcnir_top.sv ***
// lcnir_top: link control flags and node identity/status register bank
// assumes an apb master on the register side and phy status pulses that are
// synchronous to I_CLK_SYS; the 24.576 MHz count arrives as a tick pulse
//
// Behaviour
// - one written at set port sets bit
// - both ports read current control contents
// - external select rolls timer from external tick
// - otherwise roll over after 3072 ticks
// - leader and root emit cycle start per rollover
// - non-leader accepts received cycle starts
// - overlong event clears leader, blocks setting it
// - count enable advances offset, clear holds it
// - phy packets accepted when receive context enabled
// - self-identification packets accepted when enabled
// - node_identity_status is bus and node numbers
// - valid resets zero, clears on bus reset
// - root flag resets zero, follows phy root
// - cable power flag follows phy report
// - bus number writable, resets all ones
// - node number loaded from phy, read-only
// - offset runs modulo 3072, one 125 us; under external select the offset counts past 3071 until the external tick
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "lcnir_defs.svh"

module lcnir_top
  import lcnir_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // phy status
  input  wire logic        I_PHY_BUS_RESET,
  input  wire logic        I_PHY_NODE_VALID,
  input  wire logic [5:0]  I_PHY_NODE_NUM,
  input  wire logic        I_PHY_ROOT,
  input  wire logic        I_PHY_CABLE_POWER,
  // cycle timer, overlong event and receive context inputs
  input  wire logic        I_TICK_24M,
  input  wire logic        I_EXT_CYCLE_TICK,
  input  wire logic        I_OVERLONG_EVENT,
  input  wire logic        I_RX_CYCLE_START,
  input  wire logic [11:0] I_RX_CYCLE_OFFSET,
  input  wire logic        I_AR_REQ_CTX_EN,
  // link control and status outputs
  output logic             O_EXT_ROLLOVER_SELECT,
  output logic             O_TIMING_LEADER_ENABLE,
  output logic             O_TIMER_COUNT_ENABLE,
  output logic             O_ACCEPT_PHY_PACKETS,
  output logic             O_ACCEPT_SELF_IDENT,
  output logic             O_ACCEPT_CYCLE_START,
  output logic             O_CYCLE_START_REQ,
  output logic      [11:0] O_INTRA_PERIOD_COUNT,
  output logic      [15:0] O_NODE_IDENTITY_STATUS,
  output logic             O_NODE_ADDRESS_VALID
);

  lcnir_lctrl_t  lctrl_r;
  lcnir_lctrl_t  lctrl_nxt;
  lcnir_lctrl_t  set_mask;
  logic          overlong_r;
  logic          node_valid_r;
  logic          root_r;
  logic          cable_pwr_r;
  logic [9:0]    bus_num_r;
  logic [5:0]    node_num_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          cyc_start_r;
  logic          acc_phy_r;
  logic          acc_cs_r;
  lcnir_sel_t    sel;
  logic          setup;
  logic          wr_go;
  logic [31:0]   rd_word;
  logic [31:0]   node_word;
  lcnir_offset_t offset;
  logic          rollover;
  logic          rx_load;

  // ---------------------------------------------------------------- apb
  always_comb begin
    case (I_PADDR)
      `LCNIR_OFS_LCTRL_SET:  sel = LCNIR_SEL_SET;
      `LCNIR_OFS_LCTRL_CLR:  sel = LCNIR_SEL_CLR;
      `LCNIR_OFS_NODE_IDENTITY_STATUS:    sel = LCNIR_SEL_NODE;
      `LCNIR_OFS_EVENT:      sel = LCNIR_SEL_EVT;
      `LCNIR_OFS_CYC_OFFSET: sel = LCNIR_SEL_CYC;
      default:               sel = LCNIR_SEL_NONE;
    endcase
  end

  assign setup = I_PSEL && !I_PENABLE;
  // pready is registered in setup, so every transfer takes exactly two cycles
  assign wr_go = I_PSEL && I_PENABLE && pready_r && I_PWRITE;

  always_comb begin
    node_word                                           = 32'h0000_0000;
    node_word[`LCNIR_NI_VALID]                          = node_valid_r;
    node_word[`LCNIR_NI_ROOT]                           = root_r;
    node_word[`LCNIR_NI_CABLE_PWR]                      = cable_pwr_r;
    node_word[`LCNIR_NI_BUS_MSB:`LCNIR_NI_BUS_LSB]      = bus_num_r;
    node_word[`LCNIR_NI_NODE_MSB:0]                     = node_num_r;
  end

  always_comb begin
    case (sel)
      LCNIR_SEL_SET:  rd_word = {27'h0000000, lctrl_r};
      LCNIR_SEL_CLR:  rd_word = {27'h0000000, lctrl_r};
      LCNIR_SEL_NODE: rd_word = node_word;
      LCNIR_SEL_EVT:  rd_word = {31'h00000000, overlong_r};
      LCNIR_SEL_CYC:  rd_word = {20'h00000, offset};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && (sel == LCNIR_SEL_NONE);
      if (setup && !I_PWRITE) begin
        prdata_r <= rd_word;
      end
    end
  end

  // ------------------------------------------------------- link control
  always_comb begin
    set_mask = I_PWDATA[`LCNIR_LC_WIDTH-1:0];
    // leader cannot be set while the overlong flag stands
    if (overlong_r) begin
      set_mask[`LCNIR_LC_LEADER] = 1'b0;
    end
    lctrl_nxt = lctrl_r;
    if (wr_go && sel == LCNIR_SEL_SET) begin
      lctrl_nxt = lctrl_r | set_mask;
    end
    if (wr_go && sel == LCNIR_SEL_CLR) begin
      lctrl_nxt = lctrl_r & ~I_PWDATA[`LCNIR_LC_WIDTH-1:0];
    end
    if (I_OVERLONG_EVENT) begin
      lctrl_nxt[`LCNIR_LC_LEADER] = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      lctrl_r <= `LCNIR_LC_RESET;
    end else begin
      lctrl_r <= lctrl_nxt;
    end
  end

  // a new overlong event wins over a same-cycle software clear
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      overlong_r <= 1'b0;
    end else if (I_OVERLONG_EVENT) begin
      overlong_r <= 1'b1;
    end else if (wr_go && sel == LCNIR_SEL_EVT && I_PWDATA[`LCNIR_EV_OVERLONG]) begin
      overlong_r <= 1'b0;
    end
  end

  // -------------------------------------------------------- node status
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      node_valid_r <= 1'b0;
    end else if (I_PHY_NODE_VALID) begin
      node_valid_r <= 1'b1;
    end else if (I_PHY_BUS_RESET) begin
      node_valid_r <= 1'b0;
    end
  end

  // node number and root are only ever written by the phy report
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      node_num_r <= `LCNIR_NODE_RESET;
      root_r     <= 1'b0;
    end else if (I_PHY_NODE_VALID) begin
      node_num_r <= I_PHY_NODE_NUM;
      root_r     <= I_PHY_ROOT;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      cable_pwr_r <= 1'b0;
    end else begin
      cable_pwr_r <= I_PHY_CABLE_POWER;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      bus_num_r <= `LCNIR_BUS_RESET;
    end else if (wr_go && sel == LCNIR_SEL_NODE) begin
      bus_num_r <= I_PWDATA[`LCNIR_NI_BUS_MSB:`LCNIR_NI_BUS_LSB];
    end
  end

  // -------------------------------------------------------- cycle timer
  assign rx_load = I_RX_CYCLE_START && !lctrl_r[`LCNIR_LC_LEADER];

  lcnir_cycle_offset u_cycle_offset (
    .i_clk        (I_CLK_SYS),
    .i_rst_n      (I_RST_N),
    .i_count_en   (lctrl_r[`LCNIR_LC_TIMER_EN]),
    .i_ext_sel    (lctrl_r[`LCNIR_LC_EXT_ROLL]),
    .i_ext_tick   (I_EXT_CYCLE_TICK),
    .i_tick_24m   (I_TICK_24M),
    .i_load       (rx_load),
    .i_load_value (I_RX_CYCLE_OFFSET),
    .o_offset     (offset),
    .o_rollover   (rollover)
  );

  // registered gating costs one cycle of latency but keeps outputs glitch free
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      cyc_start_r <= 1'b0;
      acc_phy_r   <= 1'b0;
      acc_cs_r    <= 1'b0;
    end else begin
      cyc_start_r <= rollover && lctrl_r[`LCNIR_LC_LEADER] && root_r;
      acc_phy_r   <= lctrl_r[`LCNIR_LC_PHY_PKT] && I_AR_REQ_CTX_EN;
      acc_cs_r    <= !lctrl_r[`LCNIR_LC_LEADER];
    end
  end

  // ------------------------------------------------------------ outputs
  assign O_PRDATA               = prdata_r;
  assign O_PREADY               = pready_r;
  assign O_PSLVERR              = pslverr_r;
  assign O_EXT_ROLLOVER_SELECT  = lctrl_r[`LCNIR_LC_EXT_ROLL];
  assign O_TIMING_LEADER_ENABLE = lctrl_r[`LCNIR_LC_LEADER];
  assign O_TIMER_COUNT_ENABLE   = lctrl_r[`LCNIR_LC_TIMER_EN];
  assign O_ACCEPT_PHY_PACKETS   = acc_phy_r;
  assign O_ACCEPT_SELF_IDENT    = lctrl_r[`LCNIR_LC_SELF_ID];
  assign O_ACCEPT_CYCLE_START   = acc_cs_r;
  assign O_CYCLE_START_REQ      = cyc_start_r;
  assign O_INTRA_PERIOD_COUNT   = offset;
  assign O_NODE_IDENTITY_STATUS              = {bus_num_r, node_num_r};
  assign O_NODE_ADDRESS_VALID   = node_valid_r;

  // ---------------------------------------------------------- assertions
  sequence s_set_write;
    I_PSEL && I_PENABLE && pready_r && I_PWRITE && I_PADDR == 12'h000
      && !I_OVERLONG_EVENT;
  endsequence

  sequence s_clr_write;
    I_PSEL && I_PENABLE && pready_r && I_PWRITE && I_PADDR == 12'h004;
  endsequence

  property p_set;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (s_set_write and (!overlong_r))
      |=> (lctrl_r == ($past(lctrl_r) | $past(I_PWDATA[4:0])));
  endproperty
  a_set: assert property (p_set) else $error("set port write wrong");

  property p_clr;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (s_clr_write and (!I_OVERLONG_EVENT))
      |=> (lctrl_r == ($past(lctrl_r) & ~$past(I_PWDATA[4:0])));
  endproperty
  a_clr: assert property (p_clr) else $error("clear port write wrong");

  sequence s_ctrl_read;
    I_PSEL && !I_PENABLE && !I_PWRITE && (I_PADDR == 12'h000 || I_PADDR == 12'h004);
  endsequence

  property p_read;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_ctrl_read |=> (O_PREADY && O_PRDATA == {27'h0000000, $past(lctrl_r)});
  endproperty
  a_read: assert property (p_read) else $error("control read mismatch");

  property p_cstart;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (rollover && lctrl_r[1] && root_r) |=> O_CYCLE_START_REQ;
  endproperty
  a_cstart: assert property (p_cstart) else $error("cycle start missing");

  property p_follow;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_RX_CYCLE_START && !lctrl_r[1]) |=> (offset == $past(I_RX_CYCLE_OFFSET));
  endproperty
  a_follow: assert property (p_follow) else $error("cycle start not taken");

  property p_overlong;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    overlong_r |-> !lctrl_r[1];
  endproperty
  a_overlong: assert property (p_overlong) else $error("leader set while overlong");

  property p_phy_pkt;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    1'b1 |=> (O_ACCEPT_PHY_PACKETS == ($past(lctrl_r[3]) && $past(I_AR_REQ_CTX_EN)));
  endproperty
  a_phy_pkt: assert property (p_phy_pkt) else $error("phy packet accept wrong");

  property p_valid;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_PHY_BUS_RESET && !I_PHY_NODE_VALID) |=> !O_NODE_ADDRESS_VALID;
  endproperty
  a_valid: assert property (p_valid) else $error("valid flag not cleared");

  property p_valid_hold;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (!O_NODE_ADDRESS_VALID && !I_PHY_NODE_VALID) |=> !O_NODE_ADDRESS_VALID;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid set without node number");

  property p_node;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_PHY_NODE_VALID |=> (node_num_r == $past(I_PHY_NODE_NUM) && root_r == $past(I_PHY_ROOT)
      && O_NODE_ADDRESS_VALID);
  endproperty
  a_node: assert property (p_node) else $error("node number not loaded");

  property p_node_ro;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !I_PHY_NODE_VALID |=> $stable(node_num_r);
  endproperty
  a_node_ro: assert property (p_node_ro) else $error("node number changed");

  property p_cable;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    1'b1 |=> (cable_pwr_r == $past(I_PHY_CABLE_POWER));
  endproperty
  a_cable: assert property (p_cable) else $error("cable power flag wrong");

  property p_reset_vals;
    @(posedge I_CLK_SYS)
    !I_RST_N |=> (bus_num_r == 10'h3FF && !node_valid_r && !root_r && !cable_pwr_r);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_node_identity_status;
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (I_PSEL && I_PENABLE && pready_r && I_PWRITE && I_PADDR == 12'h008)
      |=> (O_NODE_IDENTITY_STATUS == {$past(I_PWDATA[15:6]), node_num_r});
  endproperty
  a_node_identity_status: assert property (p_node_identity_status) else $error("node_identity_status mismatch");

endmodule

// *** bench/lcnir_phy_model.sv ***
// lcnir_phy_model: behavioural phy that reports node number, root and cable power
// assumes the bench calls its tasks just after a rising edge of i_clk
`timescale 1ns/10ps

module lcnir_phy_model (
  // clock
  input  wire logic       i_clk,
  // status towards the link
  output logic            o_bus_reset,
  output logic            o_node_valid,
  output logic      [5:0] o_node_num,
  output logic            o_root,
  output logic            o_cable_power
);
  initial begin
    o_bus_reset   = 1'b0;
    o_node_valid  = 1'b0;
    o_node_num    = 6'h00;
    o_root        = 1'b0;
    o_cable_power = 1'b0;
  end

  // number and root mean nothing outside the pulse, so they show inverted junk there
  task automatic self_id(input logic [5:0] num, input logic root, input int gap);
    repeat (gap + 1) @(posedge i_clk);
    o_node_valid <= 1'b1;
    o_node_num   <= num;
    o_root       <= root;
    @(posedge i_clk);
    o_node_valid <= 1'b0;
    o_node_num   <= ~num;
    o_root       <= ~root;
  endtask

  task automatic bus_reset();
    @(posedge i_clk);
    o_bus_reset <= 1'b1;
    @(posedge i_clk);
    o_bus_reset <= 1'b0;
  endtask

  task automatic set_power(input logic ok);
    @(posedge i_clk);
    o_cable_power <= ok;
  endtask
endmodule

// *** bench/tb_link_control_node_identity_status_regs.sv ***
// tb_link_control_node_identity_status_regs: self-checking bench for the register bank
// assumes lcnir_top as an apb slave that raises pready, and a phy model beside it
`timescale 1ns/10ps
`include "lcnir_defs.svh"

module tb_link_control_node_identity_status_regs;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_rst;
  logic        node_vld;
  logic [5:0]  node_num;
  logic        root;
  logic        cpwr;
  logic        tick;
  logic        ext_tick;
  logic        overlong;
  logic        rx_start;
  logic [11:0] rx_off;
  logic        ar_en;
  logic        ext_sel;
  logic        leader;
  logic        cnt_en;
  logic        phy_pkt;
  logic        self_id;
  logic        acc_cs;
  logic        cs_req;
  logic [11:0] offset;
  logic [15:0] node_identity_status;
  logic        addr_vld;
  int          n_mismatch;
  int          checks_done;
  int          seed;
  logic [4:0]  ctrl_m;
  logic [31:0] rd;
  logic [31:0] d;
  logic        err;
  logic [9:0]  bus;
  logic [5:0]  nn;

  lcnir_top DUT (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PHY_BUS_RESET(bus_rst),
    .I_PHY_NODE_VALID(node_vld), .I_PHY_NODE_NUM(node_num), .I_PHY_ROOT(root),
    .I_PHY_CABLE_POWER(cpwr), .I_TICK_24M(tick), .I_EXT_CYCLE_TICK(ext_tick),
    .I_OVERLONG_EVENT(overlong), .I_RX_CYCLE_START(rx_start),
    .I_RX_CYCLE_OFFSET(rx_off), .I_AR_REQ_CTX_EN(ar_en),
    .O_EXT_ROLLOVER_SELECT(ext_sel), .O_TIMING_LEADER_ENABLE(leader),
    .O_TIMER_COUNT_ENABLE(cnt_en), .O_ACCEPT_PHY_PACKETS(phy_pkt),
    .O_ACCEPT_SELF_IDENT(self_id), .O_ACCEPT_CYCLE_START(acc_cs),
    .O_CYCLE_START_REQ(cs_req), .O_INTRA_PERIOD_COUNT(offset), .O_NODE_IDENTITY_STATUS(node_identity_status),
    .O_NODE_ADDRESS_VALID(addr_vld));

  lcnir_phy_model phy (
    .i_clk(clk), .o_bus_reset(bus_rst), .o_node_valid(node_vld), .o_node_num(node_num),
    .o_root(root), .o_cable_power(cpwr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] node_word(logic v, logic r, logic c, logic [9:0] b,
                                            logic [5:0] n);
    return {v, r, 2'b00, c, 11'h000, b, n};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request holds until pready is seen high at a rising edge, then is released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("apb_ready", {31'h0, pready}, 32'h1);
      print_verdict();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  task automatic pulse_ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
    end
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
  endtask

  initial begin
    seed = 7506;
    n_mismatch = 0;
    checks_done = 0;
    {rst_n, psel, penable, pwrite, tick, ext_tick, overlong, rx_start, ar_en} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_off = 12'h000;
    ctrl_m = 5'h00;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc("lc_reset", `LCNIR_OFS_LCTRL_SET, 32'h0);
    rdc("node_reset", `LCNIR_OFS_NODE_IDENTITY_STATUS, node_word(0, 0, 0, 10'h3FF, 6'h00));
    chk("node_identity_status_reset", {16'h0, node_identity_status}, 32'h0000FFC0);
    chk("addr_vld_reset", {31'h0, addr_vld}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      apb(1'b1, d[31] ? `LCNIR_OFS_LCTRL_SET : `LCNIR_OFS_LCTRL_CLR, d);
      ctrl_m = d[31] ? (ctrl_m | d[4:0]) : (ctrl_m & ~d[4:0]);
      rdc("lc_set_rd", `LCNIR_OFS_LCTRL_SET, {27'h0, ctrl_m});
      rdc("lc_clr_rd", `LCNIR_OFS_LCTRL_CLR, {27'h0, ctrl_m});
      chk("lc_outs", {28'h0, self_id, cnt_en, leader, ext_sel}, {28'h0, ctrl_m[4], ctrl_m[2:0]});
    end
    apb(1'b1, `LCNIR_OFS_LCTRL_CLR, 32'h1F);
    $display("test set clear done");
    d = $random(seed);
    nn = d[5:0];
    phy.self_id(nn, 1'b0, 2);
    rdc("node_phy0", `LCNIR_OFS_NODE_IDENTITY_STATUS, node_word(1, 0, 0, 10'h3FF, nn));
    chk("addr_vld_set", {31'h0, addr_vld}, 32'h1);
    phy.set_power(1'b1);
    phy.self_id(6'h3F, 1'b1, 1);
    d = $random(seed);
    bus = d[15:6];
    apb(1'b1, `LCNIR_OFS_NODE_IDENTITY_STATUS, d);
    rdc("node_phy1", `LCNIR_OFS_NODE_IDENTITY_STATUS, node_word(1, 1, 1, bus, 6'h3F));
    chk("node_identity_status", {16'h0, node_identity_status}, {16'h0, bus, 6'h3F});
    phy.bus_reset();
    rdc("node_busrst", `LCNIR_OFS_NODE_IDENTITY_STATUS, node_word(0, 1, 1, bus, 6'h3F));
    chk("addr_vld_clr", {31'h0, addr_vld}, 32'h0);
    $display("test node word done");
    apb(1'b1, `LCNIR_OFS_LCTRL_SET, 32'h6);
    pulse_ticks(12'hBFF);
    chk("off_last", {20'h0, offset}, 32'hBFF);
    pulse_ticks(1);
    chk("off_wrap", {20'h0, offset}, 32'h0);
    chk("start_early", {31'h0, cs_req}, 32'h0);
    @(negedge clk);
    chk("start_req", {31'h0, cs_req}, 32'h1);
    @(negedge clk);
    chk("start_once", {31'h0, cs_req}, 32'h0);
    apb(1'b1, `LCNIR_OFS_LCTRL_CLR, 32'h4);
    pulse_ticks(5);
    chk("off_hold", {20'h0, offset}, 32'h0);
    apb(1'b1, `LCNIR_OFS_LCTRL_SET, 32'h5);
    pulse_ticks(12'hBFE);
    chk("off_ext_free", {20'h0, offset}, 32'hBFE);
    pulse_ticks(5);
    chk("off_ext_past", {20'h0, offset}, 32'hC03);
    @(posedge clk);
    ext_tick <= 1'b1;
    @(posedge clk);
    ext_tick <= 1'b0;
    @(negedge clk);
    chk("off_ext_wrap", {20'h0, offset}, 32'h0);
    apb(1'b1, `LCNIR_OFS_LCTRL_CLR, 32'h1);
    $display("test cycle timer done");
    @(posedge clk);
    overlong <= 1'b1;
    @(posedge clk);
    overlong <= 1'b0;
    @(negedge clk);
    chk("leader_drop", {31'h0, leader}, 32'h0);
    rdc("event_set", `LCNIR_OFS_EVENT, 32'h1);
    apb(1'b1, `LCNIR_OFS_LCTRL_SET, 32'h2);
    rdc("leader_block", `LCNIR_OFS_LCTRL_SET, 32'h4);
    apb(1'b1, `LCNIR_OFS_EVENT, 32'h1);
    apb(1'b1, `LCNIR_OFS_LCTRL_SET, 32'h2);
    rdc("leader_again", `LCNIR_OFS_LCTRL_CLR, 32'h6);
    chk("accept_cs_off", {31'h0, acc_cs}, 32'h0);
    d = $random(seed);
    @(posedge clk);
    rx_start <= 1'b1;
    rx_off   <= d[11:0];
    @(posedge clk);
    rx_start <= 1'b0;
    rx_off   <= ~d[11:0];
    @(negedge clk);
    chk("rx_ignored", {20'h0, offset}, 32'h0);
    apb(1'b1, `LCNIR_OFS_LCTRL_CLR, 32'h2);
    repeat (2) @(negedge clk);
    chk("accept_cs", {31'h0, acc_cs}, 32'h1);
    @(posedge clk);
    rx_start <= 1'b1;
    rx_off   <= d[11:0] % 12'hC00;
    @(posedge clk);
    rx_start <= 1'b0;
    @(negedge clk);
    chk("rx_load", {20'h0, offset}, {20'h0, d[11:0] % 12'hC00});
    apb(1'b1, `LCNIR_OFS_CYC_OFFSET, 32'hFFF);
    chk("cyc_wr_err", {31'h0, err}, 32'h0);
    rdc("cyc_ro", `LCNIR_OFS_CYC_OFFSET, {20'h0, d[11:0] % 12'hC00});
    $display("test overlong and sync done");
    apb(1'b1, `LCNIR_OFS_LCTRL_SET, 32'h8);
    repeat (2) @(negedge clk);
    chk("phy_pkt_off", {31'h0, phy_pkt}, 32'h0);
    @(posedge clk);
    ar_en <= 1'b1;
    repeat (2) @(negedge clk);
    chk("phy_pkt_on", {31'h0, phy_pkt}, 32'h1);
    rdc("unmapped_rd", 12'h020, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    $display("test receive and refusal done");
    print_verdict();
  end
endmodule
